//--- dhtm_pkg.sv
// Package of register offsets, field codes and timing constants for the timer.
package dhtm_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_MODE_A = 8'h04;
	localparam logic [7:0] ADDR_MODE_B = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_LOAD_A = 8'h10;
	localparam logic [7:0] ADDR_LOAD_B = 8'h14;
	localparam logic [7:0] ADDR_MATCH_A = 8'h18;
	localparam logic [7:0] ADDR_MATCH_B = 8'h1c;
	localparam logic [7:0] ADDR_VALUE_A = 8'h20;
	localparam logic [7:0] ADDR_VALUE_B = 8'h24;
	localparam logic [7:0] ADDR_STATUS = 8'h28;
	// ----------------------------------------------------------------
	// Full-width configuration codes
	// ----------------------------------------------------------------
	localparam logic [2:0] CFG_OS_DOWN = 3'h0;
	localparam logic [2:0] CFG_OS_UP = 3'h1;
	localparam logic [2:0] CFG_PER_DOWN = 3'h2;
	localparam logic [2:0] CFG_PER_UP = 3'h3;
	localparam logic [2:0] CFG_RTC = 3'h4;
	localparam logic [2:0] CFG_SPLIT = 3'h5;
	// ----------------------------------------------------------------
	// Half-width mode codes: bit 0 selects counting up
	// ----------------------------------------------------------------
	localparam logic [3:0] HM_OS = 4'h0;
	localparam logic [3:0] HM_OS_UP = 4'h1;
	localparam logic [3:0] HM_PER = 4'h2;
	localparam logic [3:0] HM_PER_UP = 4'h3;
	localparam logic [3:0] HM_CNT = 4'h4;
	localparam logic [3:0] HM_CNT_UP = 4'h5;
	localparam logic [3:0] HM_TIME = 4'h6;
	localparam logic [3:0] HM_TIME_UP = 4'h7;
	localparam logic [3:0] HM_PWM = 4'h8;
	// ----------------------------------------------------------------
	// Capture edge selection codes
	// ----------------------------------------------------------------
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// ----------------------------------------------------------------
	// Control register bit positions, per half b adds CTRL_B_OFS
	// ----------------------------------------------------------------
	localparam int CTRL_EN = 0;
	localparam int CTRL_INV = 1;
	localparam int CTRL_STALL = 2;
	localparam int CTRL_TRIG = 3;
	localparam int CTRL_WAIT = 4;
	localparam int CTRL_EDGE = 5;
	localparam int CTRL_B_OFS = 8;
	// ----------------------------------------------------------------
	// Real-time clock prescale: 32768 Hz slow clock to one second
	// ----------------------------------------------------------------
	localparam logic [14:0] RTC_DIV_LAST = 15'h7fff;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
	localparam logic [15:0] LOAD_RESET = 16'hffff;
endpackage

//--- dhtm_timer.sv
// Dual half-width timer with mode configuration and run control.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - A write of the configuration register stops both halves and leaves them stopped.
// - The full-width configuration picks one of six modes, down or up one-shot or periodic, clock or split.
// - In split mode the first half takes one-shot, periodic, edge count, edge time (each down or up) or pulse mode.
// - The second half offers the same modes, chosen independently.
// - Each half has an inversion bit that makes its pulse output active low.
// - Each half has a stall bit that halts counting while the processor is in debug.
// - Each half has a trigger-output enable that suppresses its trigger when clear.
// - Each half may wait for the previous timer in the chain to time out before counting.
// - Each half has its own run enable, settable separately or both together.
// - A one-shot timer stops at timeout and a periodic one reloads and goes on.
// - The clock mode counts one tick per second from the slow external clock.
// - Capture modes qualify on rising, falling or both edges.
// - In pulse mode the capture pin becomes an output with an edge-aligned pulse.
module dhtm_timer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	input wire logic debug_halt,
	input wire logic slow_clk_tick,
	input wire logic chain_trig_in,
	input wire logic [1:0] ccp_in,
	output logic [1:0] ccp_out,
	output logic [1:0] ccp_oe_n,
	output logic [1:0] trig_out,
	output logic [1:0] timeout_pulse
);
	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [2:0] config_reg;
	logic [3:0] mode_reg [2];
	logic [15:0] ctrl_reg;
	logic [15:0] load_reg [2];
	logic [15:0] match_reg [2];
	logic [15:0] count_reg [2];
	logic [15:0] cap_reg [2];
	logic [1:0] wait_done_reg;
	logic [1:0] ccp_prev_reg;
	logic [14:0] rtc_div_reg;
	logic cfg_wr;
	logic split;
	logic [31:0] full_count;
	logic [31:0] full_load;
	logic [1:0] run;
	logic [1:0] tick;
	logic [1:0] expire;
	logic [1:0] edge_hit;
	logic [1:0] prev_to;
	logic full_expire;

	// Tells whether a half-width mode counts up.
	function automatic logic mode_up(input logic [3:0] m);
		mode_up = m[0] && (m != dhtm_pkg::HM_PWM);
	endfunction

	// Tells whether the half mode is one-shot or periodic timing.
	function automatic logic mode_timed(input logic [3:0] m);
		mode_timed = (m == dhtm_pkg::HM_OS) || (m == dhtm_pkg::HM_OS_UP) ||
			(m == dhtm_pkg::HM_PER) || (m == dhtm_pkg::HM_PER_UP);
	endfunction

	// Picks one control bit of a given half.
	function automatic logic ctl(input logic [15:0] c, input int h,
		input int b);
		ctl = c[b + h * dhtm_pkg::CTRL_B_OFS];
	endfunction

	// Edge field of a half.
	function automatic logic [1:0] c_edge(input logic [15:0] c, input int h);
		c_edge = c[dhtm_pkg::CTRL_EDGE + h * dhtm_pkg::CTRL_B_OFS +: 2];
	endfunction

	assign cfg_wr = wr_stb && (addr == dhtm_pkg::ADDR_CONFIG);
	assign split = (config_reg == dhtm_pkg::CFG_SPLIT);
	assign full_count = {count_reg[1], count_reg[0]};
	assign full_load = {load_reg[1], load_reg[0]};
	// Half a hears the external chain; half b hears half a's timeout.
	assign prev_to = {expire[0], chain_trig_in};

	// ----------------------------------------------------------------
	// Per-half run, edge and expiry decode
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_half
			logic [1:0] esel;
			logic rise;
			logic fall;
			assign esel = c_edge(ctrl_reg, g);
			assign rise = ccp_in[g] && !ccp_prev_reg[g];
			assign fall = !ccp_in[g] && ccp_prev_reg[g];
			// Qualifying capture edge.
			assign edge_hit[g] = (esel == dhtm_pkg::EDGE_RISE) ? rise :
				(esel == dhtm_pkg::EDGE_FALL) ? fall : (rise || fall);
			// Running: enabled, not stalled, chain released.
			assign run[g] = ctl(ctrl_reg, g, dhtm_pkg::CTRL_EN) &&
				!(ctl(ctrl_reg, g, dhtm_pkg::CTRL_STALL) && debug_halt) &&
				(!ctl(ctrl_reg, g, dhtm_pkg::CTRL_WAIT) || wait_done_reg[g]) &&
				(split || g == 0);
			// Counting event: clock cycle, or edge in edge-count mode.
			assign tick[g] = run[g] && ((mode_reg[g] == dhtm_pkg::HM_CNT ||
				mode_reg[g] == dhtm_pkg::HM_CNT_UP) ? edge_hit[g] : 1'b1);
			// Timeout at zero going down, at load going up.
			assign expire[g] = split ? (tick[g] && (mode_up(mode_reg[g]) ?
				count_reg[g] == load_reg[g] : count_reg[g] == 16'h0000)) :
				(g == 0 && full_expire);
		end
	endgenerate

	// Full-width timeout, including clock mode once per second.
	assign full_expire = run[0] && (
		(config_reg == dhtm_pkg::CFG_RTC) ? (slow_clk_tick &&
			rtc_div_reg == dhtm_pkg::RTC_DIV_LAST &&
			full_count == full_load) :
		config_reg[0] ? full_count == full_load : full_count == 32'h0);

	// ----------------------------------------------------------------
	// Configuration and control registers
	// ----------------------------------------------------------------
	// Configuration write stops both halves.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			config_reg <= dhtm_pkg::CFG_OS_DOWN;
			mode_reg[0] <= dhtm_pkg::HM_OS;
			mode_reg[1] <= dhtm_pkg::HM_OS;
			ctrl_reg <= 16'h0000;
		end else if (cfg_wr) begin
			config_reg <= (wdata[2:0] > dhtm_pkg::CFG_SPLIT) ?
				config_reg : wdata[2:0];
			mode_reg[0] <= (wdata[11:8] > dhtm_pkg::HM_PWM) ?
				mode_reg[0] : wdata[11:8];
			mode_reg[1] <= (wdata[15:12] > dhtm_pkg::HM_PWM) ?
				mode_reg[1] : wdata[15:12];
			ctrl_reg[dhtm_pkg::CTRL_EN] <= 1'b0;
			ctrl_reg[dhtm_pkg::CTRL_EN + dhtm_pkg::CTRL_B_OFS] <= 1'b0;
		end else begin
			if (wr_stb && addr == dhtm_pkg::ADDR_MODE_A &&
				wdata[3:0] <= dhtm_pkg::HM_PWM)
				mode_reg[0] <= wdata[3:0];
			if (wr_stb && addr == dhtm_pkg::ADDR_MODE_B &&
				wdata[3:0] <= dhtm_pkg::HM_PWM)
				mode_reg[1] <= wdata[3:0];
			if (wr_stb && addr == dhtm_pkg::ADDR_CTRL)
				ctrl_reg <= wdata[15:0];
			// One-shot timeout clears its own enable.
			for (int h = 0; h < 2; h++) begin
				if (expire[h] && (split ? (mode_reg[h] == dhtm_pkg::HM_OS ||
					mode_reg[h] == dhtm_pkg::HM_OS_UP) :
					(config_reg == dhtm_pkg::CFG_OS_DOWN ||
					config_reg == dhtm_pkg::CFG_OS_UP)))
					ctrl_reg[dhtm_pkg::CTRL_EN + h * dhtm_pkg::CTRL_B_OFS] <= 1'b0;
			end
		end
	end

	// Load and match values.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int h = 0; h < 2; h++) begin
				load_reg[h] <= dhtm_pkg::LOAD_RESET;
				match_reg[h] <= 16'h0000;
			end
		end else if (wr_stb) begin
			if (addr == dhtm_pkg::ADDR_LOAD_A)
				load_reg[0] <= wdata[15:0];
			if (addr == dhtm_pkg::ADDR_LOAD_B)
				load_reg[1] <= wdata[15:0];
			if (addr == dhtm_pkg::ADDR_MATCH_A)
				match_reg[0] <= wdata[15:0];
			if (addr == dhtm_pkg::ADDR_MATCH_B)
				match_reg[1] <= wdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Chain wait and edge history
	// ----------------------------------------------------------------
	// Latches the predecessor's timeout; cleared with the enable.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_done_reg <= 2'b00;
			ccp_prev_reg <= 2'b00;
		end else begin
			ccp_prev_reg <= ccp_in;
			for (int h = 0; h < 2; h++) begin
				if (!ctl(ctrl_reg, h, dhtm_pkg::CTRL_EN) || cfg_wr)
					wait_done_reg[h] <= 1'b0;
				else if (prev_to[h])
					wait_done_reg[h] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	// Clock-mode prescaler of the slow clock.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rtc_div_reg <= 15'h0000;
		else if (!run[0] || config_reg != dhtm_pkg::CFG_RTC)
			rtc_div_reg <= 15'h0000;
		else if (slow_clk_tick)
			rtc_div_reg <= rtc_div_reg + 15'h0001;
	end

	// Count, reload and capture for both widths.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int h = 0; h < 2; h++) begin
				count_reg[h] <= 16'h0000;
				cap_reg[h] <= 16'h0000;
			end
		end else if (cfg_wr) begin
			count_reg[0] <= 16'h0000;
			count_reg[1] <= 16'h0000;
		end else if (!split) begin
			if (config_reg == dhtm_pkg::CFG_RTC) begin
				if (slow_clk_tick && run[0] &&
					rtc_div_reg == dhtm_pkg::RTC_DIV_LAST)
					{count_reg[1], count_reg[0]} <= full_expire ? 32'h0 :
						full_count + 32'h1;
			end else if (run[0]) begin
				if (full_expire)
					{count_reg[1], count_reg[0]} <= config_reg[0] ? 32'h0 :
						full_load;
				else
					{count_reg[1], count_reg[0]} <= config_reg[0] ?
						full_count + 32'h1 : full_count - 32'h1;
			end else if (!ctl(ctrl_reg, 0, dhtm_pkg::CTRL_EN))
				// Stopped: down modes sit at the load value, up modes at zero.
				{count_reg[1], count_reg[0]} <= config_reg[0] ? 32'h0 :
					full_load;
		end else begin
			for (int h = 0; h < 2; h++) begin
				if (!ctl(ctrl_reg, h, dhtm_pkg::CTRL_EN))
					count_reg[h] <= mode_up(mode_reg[h]) ? 16'h0000 : load_reg[h];
				else if (expire[h])
					count_reg[h] <= mode_up(mode_reg[h]) ? 16'h0000 : load_reg[h];
				else if (tick[h])
					count_reg[h] <= mode_up(mode_reg[h]) ? count_reg[h] + 16'h1 :
						count_reg[h] - 16'h1;
				// Edge time capture holds the count at the edge.
				if (run[h] && edge_hit[h] && (mode_reg[h] == dhtm_pkg::HM_TIME ||
					mode_reg[h] == dhtm_pkg::HM_TIME_UP))
					cap_reg[h] <= count_reg[h];
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Pulse pins, trigger and timeout outputs.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ccp_out <= 2'b00;
			ccp_oe_n <= 2'b11;
			trig_out <= 2'b00;
			timeout_pulse <= 2'b00;
		end else begin
			for (int h = 0; h < 2; h++) begin
				ccp_oe_n[h] <= !(split && mode_reg[h] == dhtm_pkg::HM_PWM);
				ccp_out[h] <= ((split && mode_reg[h] == dhtm_pkg::HM_PWM &&
					ctl(ctrl_reg, h, dhtm_pkg::CTRL_EN)) ?
					(count_reg[h] > match_reg[h]) : 1'b0) ^
					ctl(ctrl_reg, h, dhtm_pkg::CTRL_INV);
				trig_out[h] <= expire[h] &&
					ctl(ctrl_reg, h, dhtm_pkg::CTRL_TRIG);
				timeout_pulse[h] <= expire[h] && (!split || mode_timed(mode_reg[h]));
			end
		end
	end

	// Register read port, data one cycle after the strobe.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			rdata <= dhtm_pkg::RESET_VALUE;
		else if (rd_stb) begin
			unique case (addr)
				dhtm_pkg::ADDR_CONFIG: rdata <= {16'h0, mode_reg[1], mode_reg[0],
					5'h0, config_reg};
				dhtm_pkg::ADDR_MODE_A: rdata <= {28'h0, mode_reg[0]};
				dhtm_pkg::ADDR_MODE_B: rdata <= {28'h0, mode_reg[1]};
				dhtm_pkg::ADDR_CTRL: rdata <= {16'h0, ctrl_reg};
				dhtm_pkg::ADDR_LOAD_A: rdata <= {16'h0, load_reg[0]};
				dhtm_pkg::ADDR_LOAD_B: rdata <= {16'h0, load_reg[1]};
				dhtm_pkg::ADDR_MATCH_A: rdata <= {16'h0, match_reg[0]};
				dhtm_pkg::ADDR_MATCH_B: rdata <= {16'h0, match_reg[1]};
				dhtm_pkg::ADDR_VALUE_A: rdata <= {16'h0, count_reg[0]};
				dhtm_pkg::ADDR_VALUE_B: rdata <= {16'h0, count_reg[1]};
				dhtm_pkg::ADDR_STATUS: rdata <= {cap_reg[1], cap_reg[0]};
				default: rdata <= 32'h0000_0000;
			endcase
		end else
			rdata <= 32'h0000_0000;
	end
endmodule
`default_nettype wire

//--- dhtm_timer_chk.sv
// Checker of bus, pin and timeout behaviour at the timer's ports.
`timescale 1ns/1ns
`default_nettype none
module dhtm_timer_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [31:0] rdata,
	input wire logic debug_halt,
	input wire logic slow_clk_tick,
	input wire logic chain_trig_in,
	input wire logic [1:0] ccp_in,
	input wire logic [1:0] ccp_out,
	input wire logic [1:0] ccp_oe_n,
	input wire logic [1:0] trig_out,
	input wire logic [1:0] timeout_pulse
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic [2:0] cfg_seen_reg;
	logic cfg_wr_now;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// Flags a configuration write on the bus.
	assign cfg_wr_now = wr_stb && addr == dhtm_pkg::ADDR_CONFIG;
	// Remembers the last legal configuration code, as the design keeps it.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_seen_reg <= dhtm_pkg::CFG_OS_DOWN;
		end else if (cfg_wr_now && wdata[2:0] <= dhtm_pkg::CFG_SPLIT) begin
			cfg_seen_reg <= wdata[2:0];
		end
	end
	// A configuration write, then three cycles without a control write.
	sequence cfg_wr;
		cfg_wr_now;
	endsequence
	sequence ctrl_quiet;
		!(wr_stb && addr == dhtm_pkg::ADDR_CTRL) [*3];
	endsequence
	a_rd_idle_zero: assert property (!rd_stb |=> rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_cfg_stops_all: assert property (
		cfg_wr ##1 ctrl_quiet |=> timeout_pulse == 2'h0)
		else $error("timeout after configuration write");
	a_one_shot_stop: assert property (
		timeout_pulse[0] && cfg_seen_reg <= dhtm_pkg::CFG_OS_UP ##1 ctrl_quiet
		|=> !timeout_pulse[0])
		else $error("one-shot timer kept running");
	a_trig_gated: assert property (
		$past(cfg_seen_reg) != dhtm_pkg::CFG_SPLIT
		|-> (trig_out & ~timeout_pulse) == 2'h0)
		else $error("trigger without timeout");
	a_oe_full_width: assert property (
		cfg_wr_now && wdata[2:0] <= dhtm_pkg::CFG_RTC |=> ##1 ccp_oe_n == 2'h3)
		else $error("pin driven in full-width mode");
	a_pwm_pin_drive: assert property (
		cfg_wr_now && wdata[2:0] == dhtm_pkg::CFG_SPLIT
		&& wdata[11:8] == dhtm_pkg::HM_PWM |=> ##1 !ccp_oe_n[0])
		else $error("pulse pin not driven");
	a_half_b_quiet: assert property (
		cfg_seen_reg != dhtm_pkg::CFG_SPLIT
		&& $past(cfg_seen_reg) != dhtm_pkg::CFG_SPLIT |-> !timeout_pulse[1])
		else $error("second half timed out in full-width mode");
	a_level_on_write: assert property (
		ccp_oe_n == 2'h3 && $changed(ccp_out) |-> $past(wr_stb, 2))
		else $error("output level changed without a write");
endmodule
bind dhtm_timer dhtm_timer_chk i_chk (.ref_clk(ref_clk), .rst(rst),
	.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata(rdata), .debug_halt(debug_halt), .slow_clk_tick(slow_clk_tick),
	.chain_trig_in(chain_trig_in), .ccp_in(ccp_in), .ccp_out(ccp_out),
	.ccp_oe_n(ccp_oe_n), .trig_out(trig_out), .timeout_pulse(timeout_pulse));
`default_nettype wire

//--- dhtm_timer_tb_top.sv
// Self-checking testbench of the dual half-width timer.
`timescale 1ns/1ns
`default_nettype none
module dhtm_timer_tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic debug_halt = 1'b0;
	logic slow_clk_tick = 1'b0;
	logic chain_trig_in = 1'b0;
	logic [1:0] ccp_in = 2'h0;
	logic [31:0] rdata, rd_val, v0, v1;
	logic [1:0] ccp_out, ccp_oe_n, trig_out, timeout_pulse;
	logic [31:0] seed = 32'h0000_6709;
	logic [1:0] edge_tab [3] = '{2'h0, 2'h1, 2'h3};
	logic [31:0] run_ctrl [6] = '{32'h5, 32'h1, 32'h11, 32'h11, 32'h100,
		32'h101};
	int n_errors = 0;
	int checks_done = 0;
	int n_to = 0;
	int n_trig = 0;
	int k;
	dhtm_timer i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.debug_halt(debug_halt), .slow_clk_tick(slow_clk_tick),
		.chain_trig_in(chain_trig_in), .ccp_in(ccp_in), .ccp_out(ccp_out),
		.ccp_oe_n(ccp_oe_n), .trig_out(trig_out), .timeout_pulse(timeout_pulse));
	// Clock of 4 ns period.
	always #2 ref_clk = ~ref_clk;
	// Slow-clock ticks and a count of first-half timeouts and triggers.
	always @(posedge ref_clk) begin
		slow_clk_tick <= ~slow_clk_tick;
		if (timeout_pulse[0] === 1'b1) n_to++;
		if (trig_out[0] === 1'b1) n_trig++;
	end
	// Xorshift source of repeatable random values.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Builds a configuration word from the mode codes.
	function automatic logic [31:0] cfg_word(logic [2:0] c, logic [3:0] a,
		logic [3:0] b);
		return {16'h0, b, a, 5'h0, c};
	endfunction
	// Bus write, then bus read whose data lands in rd_val.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		rd_val = rdata;
	endtask
	// Compares a seen value with the expected one.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hang.
	initial begin
		#100000;
		n_errors++;
		summarize();
	end
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(dhtm_pkg::ADDR_LOAD_A);
		chk(rd_val, 32'h0000_ffff);
		// Full-width one-shot and periodic, down and up, trigger on and off.
		for (int c = 0; c < 4; c++) begin
			v0 = (rnd() & 32'hf) + 32'h4;
			wr(dhtm_pkg::ADDR_LOAD_A, v0);
			wr(dhtm_pkg::ADDR_LOAD_B, 32'h0);
			wr(dhtm_pkg::ADDR_CONFIG, cfg_word(3'(c), 4'h0, 4'h0));
			rd(dhtm_pkg::ADDR_VALUE_A);
			chk(rd_val, c[0] ? 32'h0 : v0);
			n_to = 0;
			n_trig = 0;
			wr(dhtm_pkg::ADDR_CTRL, c[0] ? 32'h9 : 32'h1);
			repeat (70) @(posedge ref_clk);
			chk(32'(c[1] ? n_to > 1 : n_to == 1), 32'h1);
			chk(32'(n_trig), c[0] ? 32'(n_to) : 32'h0);
			rd(dhtm_pkg::ADDR_CTRL);
			chk(32'(rd_val[0]), 32'(c[1]));
			wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_PER_DOWN, 4'h0, 4'h0));
			rd(dhtm_pkg::ADDR_CTRL);
			chk(rd_val & 32'h101, 32'h0);
		end
		wr(dhtm_pkg::ADDR_CONFIG, 32'h6);
		rd(dhtm_pkg::ADDR_CONFIG);
		chk(32'(rd_val[2:0]), 32'(dhtm_pkg::CFG_PER_DOWN));
		wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_RTC, 4'h0, 4'h0));
		wr(dhtm_pkg::ADDR_CTRL, 32'h1);
		repeat (20) @(posedge ref_clk);
		rd(dhtm_pkg::ADDR_VALUE_A);
		chk(rd_val, 32'h0);
		$display("full-width modes done");
		// Every half mode on each half, pulse pin enable, illegal code.
		for (int m = 0; m < 9; m++) begin
			wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_SPLIT, 4'(m), 4'(8 - m)));
			rd(dhtm_pkg::ADDR_MODE_A);
			chk(rd_val, 32'(m));
			rd(dhtm_pkg::ADDR_MODE_B);
			chk(rd_val, 32'(8 - m));
			chk(32'(ccp_oe_n), {30'h0, m != 0, m != 8});
		end
		wr(dhtm_pkg::ADDR_MODE_A, 32'h9);
		rd(dhtm_pkg::ADDR_MODE_A);
		chk(rd_val, 32'h8);
		wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_SPLIT, 4'h2, 4'h2));
		for (int i = 0; i < 4; i++) begin
			wr(dhtm_pkg::ADDR_CTRL, 32'(i[0]) << 1 | 32'(i[1]) << 9);
			repeat (2) @(posedge ref_clk);
			#1;
			chk(32'(ccp_out), 32'(i));
		end
		$display("half modes done");
		// Stall in debug, chain wait and separate enables.
		wr(dhtm_pkg::ADDR_LOAD_A, 32'h40);
		wr(dhtm_pkg::ADDR_LOAD_B, 32'h40);
		debug_halt <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_SPLIT, 4'h2, 4'h2));
			wr(dhtm_pkg::ADDR_CTRL, run_ctrl[i]);
			if (i == 3) begin
				chain_trig_in <= 1'b1;
				@(posedge ref_clk);
				chain_trig_in <= 1'b0;
			end
			rd(dhtm_pkg::ADDR_VALUE_A);
			v0 = rd_val;
			rd(dhtm_pkg::ADDR_VALUE_B);
			v1 = rd_val;
			repeat (5) @(posedge ref_clk);
			rd(dhtm_pkg::ADDR_VALUE_A);
			chk(32'(v0 !== rd_val), 32'(i == 1 || i == 3 || i == 5));
			rd(dhtm_pkg::ADDR_VALUE_B);
			chk(32'(v1 !== rd_val), 32'(i > 3));
		end
		@(posedge ref_clk);
		debug_halt <= 1'b0;
		$display("run control done");
		// Edge counting on each edge selection.
		for (int e = 0; e < 3; e++) begin
			wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_SPLIT, 4'h5, 4'h0));
			wr(dhtm_pkg::ADDR_CTRL, 32'h1 | 32'(edge_tab[e]) << 5);
			k = int'(rnd() & 32'h7) + 1;
			repeat (k) begin
				ccp_in <= 2'h1;
				repeat (2) @(posedge ref_clk);
				ccp_in <= 2'h0;
				repeat (2) @(posedge ref_clk);
			end
			repeat (4) @(posedge ref_clk);
			rd(dhtm_pkg::ADDR_VALUE_A);
			chk(rd_val, e == 2 ? 32'(2 * k) : 32'(k));
		end
		$display("edge capture done");
		// Time capture of the count at a rising edge.
		wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_SPLIT,
			dhtm_pkg::HM_TIME, dhtm_pkg::HM_OS));
		wr(dhtm_pkg::ADDR_CTRL, 32'h1);
		k = int'(rnd() & 32'h7) + 1;
		repeat (k) @(posedge ref_clk);
		ccp_in <= 2'h1;
		repeat (2) @(posedge ref_clk);
		ccp_in <= 2'h0;
		rd(dhtm_pkg::ADDR_STATUS);
		chk(rd_val, 32'h40 - 32'(k));
		// Inverted pulse output: low above the match value, then high.
		wr(dhtm_pkg::ADDR_MATCH_A, 32'h20);
		wr(dhtm_pkg::ADDR_CONFIG, cfg_word(dhtm_pkg::CFG_SPLIT,
			dhtm_pkg::HM_PWM, dhtm_pkg::HM_OS));
		wr(dhtm_pkg::ADDR_CTRL, 32'h3);
		repeat (4) @(posedge ref_clk);
		#1;
		chk({30'h0, ccp_oe_n[0], ccp_out[0]}, 32'h0);
		repeat (40) @(posedge ref_clk);
		#1;
		chk(32'(ccp_out[0]), 32'h1);
		$display("time capture and pulse done");
		summarize();
	end
endmodule
`default_nettype wire
